// *** pwrmon_avg.sv ***
// Boxcar averager of voltage RMS, current RMS and active power.
// Assumes one sample strobe per new result and a length counted in samples.
`timescale 1ns/100ps
module pwrmon_avg #(
  parameter int LEN_W = 8
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   sampleValid,
  input  wire pwrmon_pkg::pwrmon_avg_t sampleIn,
  input  wire logic [LEN_W-1:0]       avgLen,
  output pwrmon_pkg::pwrmon_avg_t     avgOut
);

  localparam int ACC_W = 16 + LEN_W;

  logic [ACC_W-1:0]        sumVolt;
  logic [ACC_W-1:0]        sumCurr;
  logic signed [ACC_W-1:0] sumPow;
  logic [LEN_W-1:0]        count;
  logic [ACC_W-1:0]        next_sumVolt;
  logic [ACC_W-1:0]        next_sumCurr;
  logic signed [ACC_W-1:0] next_sumPow;
  logic                    lastSample;

  // Length zero behaves as one sample
  function automatic logic [ACC_W-1:0] divisor(input logic [LEN_W-1:0] n);
    logic [ACC_W-1:0] d;
    d = ACC_W'(n);
    return (n == '0) ? ACC_W'(1) : d;
  endfunction

  always_comb begin
    next_sumVolt = sumVolt + ACC_W'(sampleIn.volt);
    next_sumCurr = sumCurr + ACC_W'(sampleIn.curr);
    next_sumPow  = sumPow + ACC_W'(sampleIn.pow);
    lastSample   = ({1'b0, count} + 1'b1) >= {1'b0, avgLen};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sumVolt <= '0;
      sumCurr <= '0;
      sumPow  <= '0;
      count   <= '0;
      avgOut  <= '0;
    end else if (sampleValid) begin
      if (lastSample) begin
        sumVolt     <= '0;
        sumCurr     <= '0;
        sumPow      <= '0;
        count       <= '0;
        avgOut.volt <= 16'(next_sumVolt / divisor(avgLen));
        avgOut.curr <= 16'(next_sumCurr / divisor(avgLen));
        avgOut.pow  <= 16'(next_sumPow / $signed(divisor(avgLen)));
      end else begin
        sumVolt <= next_sumVolt;
        sumCurr <= next_sumCurr;
        sumPow  <= next_sumPow;
        count   <= count + 1'b1;
      end
    end
  end

endmodule

// *** pwrmon_host.sv ***
// Host model: single-cycle register reads and writes on the result bank.
// Assumes it is called at a falling clock edge; drives on falling edges.
`timescale 1ns/100ps
module pwrmon_host (
  input  wire logic        clk,
  output logic [7:0]       regAddr,
  output logic             regWrite,
  output logic             regRead,
  output logic [31:0]      regWdata,
  input  wire logic [31:0] regRdata,
  input  wire logic        regRvalid
);
  initial begin
    regAddr  = 8'h00;
    regWrite = 1'b0;
    regRead  = 1'b0;
    regWdata = 32'h00000000;
  end

  // Released data shows the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr  = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    regWdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    n = 0;
    while (regRvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    d = (n < 4) ? regRdata : 32'hxxxxxxxx;
    @(negedge clk);
  endtask
endmodule

// *** pwrmon_pkg.sv ***
// Shared constants and carrier types of the power monitor result bank.
// Assumes one 250 MHz clock and a serial front end that turns host frames
// into single-cycle register reads and writes.
package pwrmon_pkg;

  // Register addresses as seen by the serial front end
  localparam logic [7:0] RMS_AVERAGE_SHORT_ADDR     = 8'h26;
  localparam logic [7:0] RMS_AVERAGE_LONG_ADDR      = 8'h27;
  localparam logic [7:0] ACTIVE_POWER_AVG_SHORT_ADDR = 8'h28;
  localparam logic [7:0] ACTIVE_POWER_AVG_LONG_ADDR = 8'h29;
  localparam logic [7:0] INSTANTANEOUS_SAMPLES_ADDR = 8'h2a;
  localparam logic [7:0] INSTANTANEOUS_POWER_ADDR   = 8'h2c;
  localparam logic [7:0] EVENT_STATUS_ADDR          = 8'h2d;
  localparam logic [7:0] UNLOCK_CODE_ADDR           = 8'h2f;
  localparam logic [7:0] UNLOCK_STATUS_ADDR         = 8'h30;

  // Field positions
  localparam int VOLT_LSB = 0;
  localparam int CURR_LSB = 16;
  localparam int ZERO_CROSS_BIT = 0;
  localparam int FAULT_LIVE_BIT = 1;
  localparam int FAULT_LATCHED_BIT = 2;
  localparam int OVERVOLTAGE_BIT = 3;
  localparam int UNDERVOLTAGE_BIT = 4;
  localparam int CUSTOMER_MODE_BIT = 0;

  // Fixed-point format of the instantaneous fields
  localparam int Q15_FRAC = 15;

  // Code that enables customer write access
  localparam logic [31:0] CUSTOMER_CODE = 32'h4f70656e;

  // Values after reset
  localparam logic [31:0] UNLOCK_CODE_RESET = 32'h00000000;
  localparam logic [15:0] SAMPLE_RESET      = 16'h0000;
  localparam logic [31:0] READ_DATA_RESET   = 32'h00000000;

  // Width of the zero-crossing pulse in pulse mode
  localparam int CLK_PERIOD_PS = 4000;
  localparam int ZC_PULSE_NS = 32;
  localparam int ZC_PULSE_CYCLES = (ZC_PULSE_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [7:0] ZC_PULSE_COUNT = 8'(ZC_PULSE_CYCLES);

  // One set of averaged results or raw samples
  typedef struct packed {
    logic [15:0]        volt;
    logic [15:0]        curr;
    logic signed [15:0] pow;
  } pwrmon_avg_t;

  // Status word content, bit 0 last
  typedef struct packed {
    logic undervoltage;
    logic overvoltage;
    logic faultLatched;
    logic faultLive;
    logic zeroCross;
  } pwrmon_status_t;

  // Fault comparator levels
  typedef struct packed {
    logic undervoltage;
    logic overvoltage;
    logic overcurrent;
  } pwrmon_fault_t;

endpackage

// *** pwrmon_regs.sv ***
// Result and status register bank of the isolated power monitor.
// Assumes a serial front end giving one-cycle read and write strobes with
// an address; samples and results come from logic on the same clock, the
// fault comparator levels come from outside the domain.
// The zero-crossing pulse length is fixed in cycles by the package.
//
// Functional notes
// - Voltage averages read zero when current selected
// - Current averages read zero when voltage selected
// - Short RMS average: voltage low, current high
// - Long RMS average: same layout, second length
// - Short power average in low half
// - Long power average in low half
// - Instantaneous voltage is signed Q15
// - Instantaneous current in upper half, signed Q15
// - Instantaneous power is Q15 product of samples
// - Status bits: crossing, fault, latched, over, under
// - Crossing flag follows half-cycle and square-wave
// - Live fault flags follow present conditions
// - Latched overcurrent sticks until written one
// - Latched overcurrent ignores output pin setup
// - Access status bit shows customer mode
`timescale 1ns/100ps
module pwrmon_regs #(
  parameter int SHORT_LEN_W = 8,
  parameter int LONG_LEN_W  = 16
) (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic [7:0]             regAddr,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  input  wire logic [31:0]            regWdata,
  output logic      [31:0]            regRdata,
  output logic                        regRvalid,
  input  wire logic                   sampleValid,
  input  wire logic [15:0]            rmsVolt,
  input  wire logic [15:0]            rmsCurr,
  input  wire logic signed [15:0]     powActive,
  input  wire logic signed [15:0]     instVolt,
  input  wire logic signed [15:0]     instCurr,
  input  wire logic                   avgSelCurrent,
  input  wire logic [SHORT_LEN_W-1:0] avgLenShort,
  input  wire logic [LONG_LEN_W-1:0]  avgLenLong,
  input  wire logic                   halfcycleEn,
  input  wire logic                   squarewaveEn,
  input  wire logic                   overcurrentIn,
  input  wire logic                   overvoltageIn,
  input  wire logic                   undervoltageIn,
  output logic                        customerMode
);

  pwrmon_pkg::pwrmon_avg_t    rmsSample;
  pwrmon_pkg::pwrmon_avg_t    avgShort;
  pwrmon_pkg::pwrmon_avg_t    avgLong;
  pwrmon_pkg::pwrmon_fault_t  faultRaw;
  pwrmon_pkg::pwrmon_fault_t  faultSync;
  pwrmon_pkg::pwrmon_status_t status;
  logic signed [15:0]         voltSample;
  logic signed [15:0]         currSample;
  logic signed [15:0]         powSample;
  logic                       prevNegative;
  logic                       riseCross;
  logic                       fallCross;
  logic                       squareLevel;
  logic [7:0]                 pulseCount;
  logic                       zeroCross;
  logic                       faultLatched;
  logic                       clearLatched;
  logic [31:0]                unlockCode;
  logic [31:0]                next_regRdata;

  // Q15 times Q15 back to Q15; only -1 times -1 overflows
  function automatic logic [15:0] q15Mul(input logic signed [15:0] a,
                                         input logic signed [15:0] b);
    logic signed [31:0] p;
    p = a * b;
    if (p == 32'sh40000000) begin
      return 16'h7fff;
    end
    return p[pwrmon_pkg::Q15_FRAC +: 16];
  endfunction

  // A selected RMS half reads its value, the other half zero
  function automatic logic [31:0] rmsWord(input pwrmon_pkg::pwrmon_avg_t r,
                                          input logic selCurrent);
    logic [31:0] w;
    w = '0;
    if (selCurrent) begin
      w[pwrmon_pkg::CURR_LSB +: 16] = r.curr;
    end else begin
      w[pwrmon_pkg::VOLT_LSB +: 16] = r.volt;
    end
    return w;
  endfunction

  // Signed 16-bit value in the low half, upper bits zero
  function automatic logic [31:0] lowHalf(input logic [15:0] v);
    logic [31:0] w;
    w = '0;
    w[pwrmon_pkg::VOLT_LSB +: 16] = v;
    return w;
  endfunction

  // Strobe aimed at one register address
  function automatic logic regHit(input logic       strobe,
                                  input logic [7:0] at,
                                  input logic [7:0] target);
    return strobe && (at == target);
  endfunction

  // Flags at their fixed positions, every other bit reads zero
  function automatic logic [31:0] statusWord(input pwrmon_pkg::pwrmon_status_t s);
    logic [31:0] w;
    w = '0;
    w[pwrmon_pkg::ZERO_CROSS_BIT]    = s.zeroCross;
    w[pwrmon_pkg::FAULT_LIVE_BIT]    = s.faultLive;
    w[pwrmon_pkg::FAULT_LATCHED_BIT] = s.faultLatched;
    w[pwrmon_pkg::OVERVOLTAGE_BIT]   = s.overvoltage;
    w[pwrmon_pkg::UNDERVOLTAGE_BIT]  = s.undervoltage;
    return w;
  endfunction

  assign rmsSample.volt = rmsVolt;
  assign rmsSample.curr = rmsCurr;
  assign rmsSample.pow  = powActive;

  // Short and long averaging engines
  pwrmon_avg #(
    .LEN_W       (SHORT_LEN_W)
  ) avgShortEngine (
    .clk         (clk),
    .rstn        (rstn),
    .sampleValid (sampleValid),
    .sampleIn    (rmsSample),
    .avgLen      (avgLenShort),
    .avgOut      (avgShort)
  );

  pwrmon_avg #(
    .LEN_W       (LONG_LEN_W)
  ) avgLongEngine (
    .clk         (clk),
    .rstn        (rstn),
    .sampleValid (sampleValid),
    .sampleIn    (rmsSample),
    .avgLen      (avgLenLong),
    .avgOut      (avgLong)
  );

  // Fault comparators arrive from another domain
  // Filtered so that a one-cycle glitch never sets a flag
  assign faultRaw.overcurrent  = overcurrentIn;
  assign faultRaw.overvoltage  = overvoltageIn;
  assign faultRaw.undervoltage = undervoltageIn;

  pwrmon_sync #(
    .WIDTH   (3)
  ) faultSyncer (
    .clk     (clk),
    .rstn    (rstn),
    .asyncIn (faultRaw),
    .syncOut (faultSync)
  );

  // Instantaneous samples
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      voltSample <= pwrmon_pkg::SAMPLE_RESET;
      currSample <= pwrmon_pkg::SAMPLE_RESET;
    end else if (sampleValid) begin
      voltSample <= instVolt;
      currSample <= instCurr;
    end
  end

  // Product of the same sample pair that the sample register holds
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      powSample <= pwrmon_pkg::SAMPLE_RESET;
    end else if (sampleValid) begin
      powSample <= q15Mul(instVolt, instCurr);
    end
  end

  // Voltage sign history for crossing detection
  always_comb begin
    riseCross = sampleValid && prevNegative && !instVolt[15];
    fallCross = sampleValid && !prevNegative && instVolt[15];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prevNegative <= 1'b0;
    end else if (sampleValid) begin
      prevNegative <= instVolt[15];
    end
  end

  // Square wave: polarity per half cycle, or a toggle per full cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      squareLevel <= 1'b0;
    end else if (halfcycleEn) begin
      if (riseCross) begin
        squareLevel <= 1'b1;
      end else if (fallCross) begin
        squareLevel <= 1'b0;
      end
    end else if (riseCross) begin
      squareLevel <= !squareLevel;
    end
  end

  // Pulse mode: fixed-width pulse on each counted crossing
  // Reloaded per crossing, so close crossings stretch the pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pulseCount <= '0;
    end else if (riseCross || (halfcycleEn && fallCross)) begin
      pulseCount <= pwrmon_pkg::ZC_PULSE_COUNT;
    end else if (pulseCount != '0) begin
      pulseCount <= pulseCount - 1'b1;
    end
  end

  // Flag is always present, shaped by the two mode settings
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      zeroCross <= 1'b0;
    end else if (squarewaveEn) begin
      zeroCross <= squareLevel;
    end else begin
      zeroCross <= (pulseCount != '0);
    end
  end

  // Write one to the latched bit clears it
  always_comb begin
    clearLatched = regHit(regWrite, regAddr, pwrmon_pkg::EVENT_STATUS_ADDR)
                   && regWdata[pwrmon_pkg::FAULT_LATCHED_BIT];
  end

  // A fault in the clearing cycle keeps the bit set
  // so an event during a host clear is never lost
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      faultLatched <= 1'b0;
    end else if (faultSync.overcurrent) begin
      faultLatched <= 1'b1;
    end else if (clearLatched) begin
      faultLatched <= 1'b0;
    end
  end

  // Status word content
  always_comb begin
    status.zeroCross    = zeroCross;
    status.faultLive    = faultSync.overcurrent;
    status.faultLatched = faultLatched;
    status.overvoltage  = faultSync.overvoltage;
    status.undervoltage = faultSync.undervoltage;
  end

  // Access code register keeps the last written word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unlockCode <= pwrmon_pkg::UNLOCK_CODE_RESET;
    end else if (regHit(regWrite, regAddr, pwrmon_pkg::UNLOCK_CODE_ADDR)) begin
      unlockCode <= regWdata;
    end
  end

  // Customer mode only while the exact code is held
  // Compared every cycle, so writing any other value locks again
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      customerMode <= 1'b0;
    end else begin
      customerMode <= (unlockCode == pwrmon_pkg::CUSTOMER_CODE);
    end
  end

  // Read data multiplexer
  // Unmapped addresses read zero; writes to them are dropped
  always_comb begin
    next_regRdata = '0;
    case (regAddr)
      pwrmon_pkg::RMS_AVERAGE_SHORT_ADDR: begin
        next_regRdata = rmsWord(avgShort, avgSelCurrent);
      end
      pwrmon_pkg::RMS_AVERAGE_LONG_ADDR: begin
        next_regRdata = rmsWord(avgLong, avgSelCurrent);
      end
      pwrmon_pkg::ACTIVE_POWER_AVG_SHORT_ADDR: begin
        next_regRdata = lowHalf(avgShort.pow);
      end
      pwrmon_pkg::ACTIVE_POWER_AVG_LONG_ADDR: begin
        next_regRdata = lowHalf(avgLong.pow);
      end
      pwrmon_pkg::INSTANTANEOUS_SAMPLES_ADDR: begin
        next_regRdata[pwrmon_pkg::VOLT_LSB +: 16] = voltSample;
        next_regRdata[pwrmon_pkg::CURR_LSB +: 16] = currSample;
      end
      pwrmon_pkg::INSTANTANEOUS_POWER_ADDR: begin
        next_regRdata = lowHalf(powSample);
      end
      pwrmon_pkg::EVENT_STATUS_ADDR: begin
        next_regRdata = statusWord(status);
      end
      pwrmon_pkg::UNLOCK_CODE_ADDR: begin
        next_regRdata = unlockCode;
      end
      pwrmon_pkg::UNLOCK_STATUS_ADDR: begin
        next_regRdata[pwrmon_pkg::CUSTOMER_MODE_BIT] = customerMode;
      end
      default: begin
        next_regRdata = '0;
      end
    endcase
  end

  // Read data holds until the next read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= pwrmon_pkg::READ_DATA_RESET;
    end else if (regRead) begin
      regRdata <= next_regRdata;
    end
  end

  // Answer one cycle after the read strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
    end
  end

endmodule

// *** pwrmon_regs_sva.sv ***
// Checker of the result bank's register port, status word and unlock bit.
// Sees only the top module's ports; bound to every instance below.
`timescale 1ns/100ps
module pwrmon_regs_sva (
  input wire logic               clk,
  input wire logic               rstn,
  input wire logic [7:0]         regAddr,
  input wire logic               regWrite,
  input wire logic               regRead,
  input wire logic [31:0]        regWdata,
  input wire logic [31:0]        regRdata,
  input wire logic               regRvalid,
  input wire logic               sampleValid,
  input wire logic signed [15:0] instVolt,
  input wire logic signed [15:0] instCurr,
  input wire logic               avgSelCurrent,
  input wire logic               overcurrentIn,
  input wire logic               overvoltageIn,
  input wire logic               undervoltageIn,
  input wire logic               customerMode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Last sample pair taken by the bank
  logic [31:0] lastSample;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lastSample <= 32'h00000000;
    end else if (sampleValid) begin
      lastSample <= {instCurr, instVolt};
    end
  end

  AST_READ_ANSWER: assert property (regRead |=> regRvalid)
    else $error("read strobe got no answer");
  AST_VOLT_MASKED: assert property (
    regRead && avgSelCurrent && regAddr[7:1] == 7'h13 |=> regRdata[15:0] == 16'h0000)
    else $error("voltage average not zero");
  AST_CURR_MASKED: assert property (
    regRead && !avgSelCurrent && regAddr[7:1] == 7'h13 |=> regRdata[31:16] == 16'h0000)
    else $error("current average not zero");
  AST_POWER_LOW_HALF: assert property (
    regRead && regAddr[7:1] == 7'h14 |=> regRdata[31:16] == 16'h0000)
    else $error("power average outside low half");
  AST_SAMPLE_FIELDS: assert property (
    regRead && regAddr == 8'h2a |=> regRdata == $past(lastSample))
    else $error("instantaneous samples misplaced");
  AST_LIVE_FLAGS: assert property (
    $stable({overcurrentIn, overvoltageIn, undervoltageIn})[*6] ##0 (regRead && regAddr == 8'h2d)
    |=> regRdata[4:3] == $past({undervoltageIn, overvoltageIn}) && regRdata[1] == $past(overcurrentIn))
    else $error("live fault flag wrong");
  AST_LATCH_SET: assert property (
    overcurrentIn[*6] ##0 (regRead && regAddr == 8'h2d) |=> regRdata[2])
    else $error("latched fault not set");
  AST_LATCH_CLEAR: assert property (
    (!overcurrentIn)[*6] ##0 (regWrite && regAddr == 8'h2d && regWdata[2]) ##1 (regRead && regAddr == 8'h2d)
    |=> !regRdata[2])
    else $error("latched fault not cleared");
  AST_UNLOCK: assert property (
    regWrite && regAddr == 8'h2f |-> ##2 customerMode == $past(regWdata == pwrmon_pkg::CUSTOMER_CODE, 2))
    else $error("access mode does not match code");
  AST_MODE_READ: assert property (
    regRead && regAddr == 8'h30 |=> regRdata[0] == $past(customerMode))
    else $error("access status bit wrong");

  COV_UNLOCK: cover property (customerMode);
  COV_LATCHED: cover property (regRvalid && regRdata[2]);
  COV_CROSSING: cover property (regRvalid && regRdata[0]);
endmodule

bind pwrmon_regs pwrmon_regs_sva sva (
  .clk, .rstn, .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .regRvalid, .sampleValid,
  .instVolt, .instCurr, .avgSelCurrent, .overcurrentIn, .overvoltageIn, .undervoltageIn, .customerMode
);

// *** pwrmon_sync.sv ***
// Three-stage synchroniser for levels from outside the clock domain.
// The output follows only once stages two and three agree.
`timescale 1ns/100ps
module pwrmon_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Each bit moves only when the two later stages agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncOut <= '0;
    end else begin
      syncOut <= (stage2 & stage3) | (syncOut & (stage2 | stage3));
    end
  end

endmodule

// *** testbench.sv ***
// Self-checking bench of the result bank: host model on the register port,
// samples, shaping controls and fault levels driven here on falling edges.
`timescale 1ns/100ps
module testbench;
  localparam logic [31:0] ALL = 32'hffffffff;
  logic        clk, rstn, regWrite, regRead, regRvalid, sampleValid, avgSelCurrent;
  logic        halfcycleEn, squarewaveEn, overcurrentIn, overvoltageIn, undervoltageIn, customerMode;
  logic [7:0]  regAddr, avgLenShort;
  logic [15:0] rmsVolt, rmsCurr, powActive, instVolt, instCurr, avgLenLong;
  logic [31:0] regWdata, regRdata;
  int          miscompares, totalChecks, cycles;

  pwrmon_regs dut (.clk, .rstn, .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .regRvalid,
    .sampleValid, .rmsVolt, .rmsCurr, .powActive, .instVolt, .instCurr, .avgSelCurrent, .avgLenShort,
    .avgLenLong, .halfcycleEn, .squarewaveEn, .overcurrentIn, .overvoltageIn, .undervoltageIn, .customerMode);
  pwrmon_host host (.clk, .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .regRvalid);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      closeOut();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] d;
    host.rd(a, d);
    chk($sformatf("reg %h", a), exp, d & mask);
  endtask

  task automatic smp(input logic [15:0] iv, ic, rv, rc, p);
    {instVolt, instCurr, rmsVolt, rmsCurr, powActive} = {iv, ic, rv, rc, p};
    sampleValid = 1'b1;
    @(negedge clk);
    sampleValid = 1'b0;
    @(negedge clk);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic testReset();
    rdChk(8'h2d, ALL, 32'h00000000);
    rdChk(8'h30, 32'h00000001, 32'h00000000);
    rdChk(8'h2f, ALL, pwrmon_pkg::UNLOCK_CODE_RESET);
    rdChk(8'h31, ALL, 32'h00000000);
    chk("customerMode", 32'h00000000, {31'h0, customerMode});
  endtask

  // Short window of one sample, long window of two
  task automatic testAverages();
    smp(16'h0000, 16'h0000, 16'h1000, 16'h2000, 16'hff00);
    smp(16'h0000, 16'h0000, 16'h3000, 16'h4000, 16'hfd00);
    rdChk(8'h26, ALL, 32'h00003000);
    rdChk(8'h27, ALL, 32'h00002000);
    rdChk(8'h28, ALL, 32'h0000fd00);
    rdChk(8'h29, ALL, 32'h0000fe00);
    avgSelCurrent = 1'b1;
    rdChk(8'h26, ALL, 32'h40000000);
    rdChk(8'h27, ALL, 32'h30000000);
  endtask

  task automatic testInstant();
    logic [15:0] tv [4] = '{16'h4000, 16'h8000, 16'h7fff, 16'h8000};
    logic [15:0] tc [4] = '{16'hc000, 16'h8000, 16'h7fff, 16'h7fff};
    logic [15:0] tp [4] = '{16'he000, 16'h7fff, 16'h7ffe, 16'h8001};
    for (int i = 0; i < 4; i++) begin
      smp(tv[i], tc[i], 16'h0000, 16'h0000, 16'h0000);
      rdChk(8'h2a, ALL, {tc[i], tv[i]});
      rdChk(8'h2c, ALL, {16'h0000, tp[i]});
    end
    host.wr(8'h2a, ALL);
    rdChk(8'h2a, ALL, {tc[3], tv[3]});
  endtask

  // Pulse mode first, falling crossings only with half-cycle on, then square mode
  task automatic testZeroCross();
    for (int h = 0; h < 2; h++) begin
      halfcycleEn = h[0];
      smp(16'h1000, 16'h1000, 16'h0000, 16'h0000, 16'h0000);
      idle(3);
      rdChk(8'h2d, 32'h00000001, 32'h00000001);
      idle(12);
      rdChk(8'h2d, 32'h00000001, 32'h00000000);
      smp(16'hf000, 16'hf000, 16'h0000, 16'h0000, 16'h0000);
      idle(3);
      rdChk(8'h2d, 32'h00000001, {31'h0, h[0]});
      idle(12);
    end
    squarewaveEn = 1'b1;
    smp(16'h1000, 16'h1000, 16'h0000, 16'h0000, 16'h0000);
    idle(3);
    rdChk(8'h2d, 32'h00000001, 32'h00000001);
    smp(16'hf000, 16'hf000, 16'h0000, 16'h0000, 16'h0000);
    idle(3);
    rdChk(8'h2d, 32'h00000001, 32'h00000000);
    // Square mode with half-cycle off toggles on rising crossings only
    halfcycleEn = 1'b0;
    for (int k = 0; k < 2; k++) begin
      smp(16'h1000, 16'h1000, 16'h0000, 16'h0000, 16'h0000);
      idle(3);
      rdChk(8'h2d, 32'h00000001, {31'h0, ~k[0]});
      smp(16'hf000, 16'hf000, 16'h0000, 16'h0000, 16'h0000);
      idle(3);
      rdChk(8'h2d, 32'h00000001, {31'h0, ~k[0]});
    end
  endtask

  task automatic testFaults();
    logic [31:0] te [3] = '{32'h00000006, 32'h0000000c, 32'h00000014};
    for (int i = 0; i < 3; i++) begin
      {undervoltageIn, overvoltageIn, overcurrentIn} = 3'b001 << i;
      idle(6);
      rdChk(8'h2d, 32'h0000001e, te[i]);
    end
    {undervoltageIn, overvoltageIn, overcurrentIn} = 3'b000;
    idle(6);
    rdChk(8'h2d, 32'h0000001e, 32'h00000004);
    host.wr(8'h2d, 32'h00000004);
    rdChk(8'h2d, 32'h0000001e, 32'h00000000);
    // A clear while the fault stands leaves the bit set
    overcurrentIn = 1'b1;
    idle(6);
    host.wr(8'h2d, 32'h00000004);
    rdChk(8'h2d, 32'h00000006, 32'h00000006);
    overcurrentIn = 1'b0;
    idle(6);
    host.wr(8'h2d, 32'h00000004);
    rdChk(8'h2d, 32'h00000006, 32'h00000000);
  endtask

  task automatic testUnlock();
    host.wr(8'h2f, 32'h4f70656f);
    idle(1);
    rdChk(8'h30, 32'h00000001, 32'h00000000);
    host.wr(8'h2f, pwrmon_pkg::CUSTOMER_CODE);
    idle(1);
    rdChk(8'h30, 32'h00000001, 32'h00000001);
    rdChk(8'h2f, ALL, pwrmon_pkg::CUSTOMER_CODE);
    chk("customerMode", 32'h00000001, {31'h0, customerMode});
    host.wr(8'h2f, 32'h00000000);
    idle(1);
    rdChk(8'h30, 32'h00000001, 32'h00000000);
  endtask

  task automatic closeOut();
    $display("checks %0d miscompares %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    {rstn, sampleValid, avgSelCurrent, halfcycleEn, squarewaveEn} = 5'h00;
    {overcurrentIn, overvoltageIn, undervoltageIn} = 3'h0;
    {rmsVolt, rmsCurr, powActive, instVolt, instCurr} = 80'h0;
    avgLenShort = 8'h01;
    avgLenLong = 16'h0002;
    idle(5);
    rstn = 1'b1;
    idle(1);
    testReset();
    testAverages();
    testInstant();
    testZeroCross();
    testFaults();
    testUnlock();
    closeOut();
  end
endmodule
